// ---- rtl/alarm_pkg.sv ----
// Shared constants and types for the converter alarm monitor.
// Assumes a 14-bit converter core and a 32-bit serial frame.
package alarm_pkg;

    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int CODE_W = 14;
    localparam int WIDE_W = 16;
    localparam int FRAME_W = 32;
    localparam int CNT_W = 6;
    localparam int FLAG_W = 8;
    localparam int SEL_W = 2;
    localparam int CODE_LSB_POS = 18;
    localparam int FLAG_LSB_POS = 10;
    localparam int PAD_W = 10;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [SEL_W-1:0] PIN_SEL_ALARM = 2'h1;
    localparam logic [CODE_W-1:0] CODE_RESET = 14'h0;
    localparam logic [FRAME_W-1:0] WORD_RESET = 32'h0;
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h0;
    localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
    localparam logic [WIDE_W-1:0] WIDE_ONE = 16'h1;
    localparam logic [PAD_W-1:0] PAD_ZERO = 10'h0;
    localparam logic PIN_RESET = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CODE_W-1:0] upper;
        logic [CODE_W-1:0] lower;
        logic [CODE_W-1:0] hyst;
    } thresh_cfg_t;

    typedef struct packed {
        logic in_hi;
        logic in_lo;
        logic sup_hi;
        logic sup_lo;
    } alarm_set_t;

    typedef struct packed {
        alarm_set_t active;
        alarm_set_t tripped;
    } alarm_flags_t;

    localparam alarm_flags_t FLAGS_RESET = '0;

    typedef enum {FRAME_IDLE, FRAME_OPEN} frame_state_t;

endpackage

// ---- rtl/limit_hysteresis.sv ----
// Hysteresis comparator for one input limit.
// Assumes code, threshold and hysteresis are unsigned straight binary.
module limit_hysteresis
    import alarm_pkg::*;
(
    input wire logic [CODE_W-1:0] code,
    input wire logic [CODE_W-1:0] thresh,
    input wire logic [CODE_W-1:0] hyst,
    input wire logic upper_limit,
    input wire logic state_now,
    output logic state_next
);

    function automatic logic [WIDE_W-1:0] widen(
        input logic [CODE_W-1:0] v
    );
        widen = {{(WIDE_W - CODE_W){1'b0}}, v};
    endfunction

    logic [WIDE_W-1:0] code_w;
    logic [WIDE_W-1:0] thr_w;
    logic [WIDE_W-1:0] code_band;
    logic [WIDE_W-1:0] thr_band;

    // ------------------------------------------------------------
    // Set and release points
    // ------------------------------------------------------------
    // wide unsigned compare
    // Terms moved across so nothing can wrap below zero.
    always_comb begin
        code_w = widen(code);
        thr_w = widen(thresh);
        code_band = code_w + widen(hyst) + WIDE_ONE;
        thr_band = thr_w + widen(hyst) + WIDE_ONE;
        if (upper_limit) begin
            if (!state_now) begin
                state_next = code_w > thr_w;
            end else begin
                state_next = !(code_band <= thr_w);
            end
        end else begin
            if (!state_now) begin
                state_next = code_w < thr_w;
            end else begin
                state_next = !(code_w >= thr_band);
            end
        end
    end

endmodule

// ---- rtl/adc_alarm_monitor.sv ----
// Alarm and result-flag logic of a 14-bit converter, plus the
// 32-bit serial shift register facing the host.
// Assumes conv_done and conv_code come from logic on clk; the supply
// comparator outputs are asynchronous; sclk is the host's clock.
module adc_alarm_monitor
    import alarm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic convert_chip_select_n,
    input wire logic sdi,
    output logic sdo,
    input wire logic conv_done,
    input wire logic [CODE_W-1:0] conv_code,
    input wire logic supply_over_raw,
    input wire logic supply_under_raw,
    input wire logic [SEL_W-1:0] secondary_pin_function_sel,
    input wire logic input_limit_disable,
    input wire logic supply_limit_disable,
    input wire thresh_cfg_t thresh,
    input wire logic [FLAG_W-1:0] output_word_control,
    input wire logic alarm_flags_read,
    input wire logic other_pin_level,
    output logic multi_function_out_pin,
    output alarm_flags_t alarm_flags,
    output logic [FRAME_W-1:0] rx_word,
    output logic rx_valid,
    output logic conv_start
);

    // ------------------------------------------------------------
    // Supply comparator synchronisers
    // ------------------------------------------------------------
    logic sup_hi_s1_q;
    logic sup_hi_s2_q;
    logic sup_lo_s1_q;
    logic sup_lo_s2_q;
    logic sup_hi_s1_d;
    logic sup_hi_s2_d;
    logic sup_lo_s1_d;
    logic sup_lo_s2_d;

    always_comb begin
        sup_hi_s1_d = supply_over_raw;
        sup_hi_s2_d = sup_hi_s1_q;
        sup_lo_s1_d = supply_under_raw;
        sup_lo_s2_d = sup_lo_s1_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sup_hi_s1_q <= 1'b0;
            sup_hi_s2_q <= 1'b0;
            sup_lo_s1_q <= 1'b0;
            sup_lo_s2_q <= 1'b0;
        end else begin
            sup_hi_s1_q <= sup_hi_s1_d;
            sup_hi_s2_q <= sup_hi_s2_d;
            sup_lo_s1_q <= sup_lo_s1_d;
            sup_lo_s2_q <= sup_lo_s2_d;
        end
    end

    // ------------------------------------------------------------
    // Input limit comparators
    // ------------------------------------------------------------
    logic in_hi_st_q;
    logic in_lo_st_q;
    logic in_hi_next;
    logic in_lo_next;

    limit_hysteresis u_upper (
        .code(conv_code),
        .thresh(thresh.upper),
        .hyst(thresh.hyst),
        .upper_limit(1'b1),
        .state_now(in_hi_st_q),
        .state_next(in_hi_next)
    );

    limit_hysteresis u_lower (
        .code(conv_code),
        .thresh(thresh.lower),
        .hyst(thresh.hyst),
        .upper_limit(1'b0),
        .state_now(in_lo_st_q),
        .state_next(in_lo_next)
    );

    // ------------------------------------------------------------
    // Alarm flags
    // ------------------------------------------------------------
    logic [CODE_W-1:0] code_q;
    logic [CODE_W-1:0] code_d;
    logic in_hi_st_d;
    logic in_lo_st_d;
    alarm_flags_t flags_q;
    alarm_flags_t flags_d;
    alarm_set_t fresh;

    always_comb begin
        code_d = code_q;
        in_hi_st_d = in_hi_st_q;
        in_lo_st_d = in_lo_st_q;
        flags_d = flags_q;
        in_hi_st_d = conv_done ? in_hi_next : in_hi_st_q;
        in_lo_st_d = conv_done ? in_lo_next : in_lo_st_q;
        fresh.in_hi = in_hi_next & ~input_limit_disable;
        fresh.in_lo = in_lo_next & ~input_limit_disable;
        fresh.sup_hi = sup_hi_s2_q & ~supply_limit_disable;
        fresh.sup_lo = sup_lo_s2_q & ~supply_limit_disable;
        if (alarm_flags_read) begin
            flags_d.tripped = '0;
        end
        if (conv_done) begin
            code_d = conv_code;
            flags_d.active = fresh;
            // trigger sets both flags
            // A trip landing on a read cycle still sticks.
            flags_d.tripped = flags_d.tripped | fresh;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            code_q <= CODE_RESET;
            in_hi_st_q <= 1'b0;
            in_lo_st_q <= 1'b0;
            flags_q <= FLAGS_RESET;
        end else begin
            code_q <= code_d;
            in_hi_st_q <= in_hi_st_d;
            in_lo_st_q <= in_lo_st_d;
            flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------
    // Multi-function pin
    // ------------------------------------------------------------
    logic pin_q;
    logic pin_d;

    always_comb begin
        if (secondary_pin_function_sel == PIN_SEL_ALARM) begin
            pin_d = |flags_q.active;
        end else begin
            pin_d = other_pin_level;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_q <= PIN_RESET;
        end else begin
            pin_q <= pin_d;
        end
    end

    // ------------------------------------------------------------
    // Chip-select crossing and frame tracking
    // ------------------------------------------------------------
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s1_d;
    logic cs_s2_d;
    frame_state_t frame_q;
    frame_state_t frame_d;
    logic [FRAME_W-1:0] tx_word_q;
    logic [FRAME_W-1:0] tx_word_d;
    logic [FRAME_W-1:0] rx_word_q;
    logic [FRAME_W-1:0] rx_word_d;
    logic rx_valid_q;
    logic rx_valid_d;
    logic start_q;
    logic start_d;
    logic [FRAME_W-1:0] rx_shift_q;
    logic [CNT_W-1:0] bit_cnt_q;
    logic first_q;
    logic lk_s1_q;
    logic lk_s2_q;
    logic lk_s1_d;
    logic lk_s2_d;
    logic seen_q;
    logic seen_d;

    always_comb begin
        cs_s1_d = convert_chip_select_n;
        cs_s2_d = cs_s1_q;
        lk_s1_d = first_q;
        lk_s2_d = lk_s1_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            lk_s1_q <= 1'b1;
            lk_s2_q <= 1'b1;
        end else begin
            cs_s1_q <= cs_s1_d;
            cs_s2_q <= cs_s2_d;
            lk_s1_q <= lk_s1_d;
            lk_s2_q <= lk_s2_d;
        end
    end

    always_comb begin
        frame_d = frame_q;
        tx_word_d = tx_word_q;
        rx_word_d = rx_word_q;
        rx_valid_d = 1'b0;
        start_d = 1'b0;
        seen_d = seen_q;
        case (frame_q)
            FRAME_IDLE: begin
                seen_d = 1'b0;
                // Word is frozen while a frame is open, so the
                // link side may read it without a handshake.
                // selected flags appended
                tx_word_d = {code_q,
                             flags_q & output_word_control,
                             PAD_ZERO};
                if (!cs_s2_q) begin
                    frame_d = FRAME_OPEN;
                end
            end
            FRAME_OPEN: begin
                // rise ends frame, starts conversion
                // The link clock is idle now, so its shift
                // register and count are stable to sample.
                // An edgeless frame would leave the old count.
                if (!lk_s2_q) begin
                    seen_d = 1'b1;
                end
                if (cs_s2_q) begin
                    frame_d = FRAME_IDLE;
                    start_d = 1'b1;
                    rx_word_d = rx_shift_q;
                    rx_valid_d = seen_q && (bit_cnt_q == CNT_FULL);
                end
            end
            default: begin
                frame_d = FRAME_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            frame_q <= FRAME_IDLE;
            tx_word_q <= WORD_RESET;
            rx_word_q <= WORD_RESET;
            rx_valid_q <= 1'b0;
            start_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            frame_q <= frame_d;
            tx_word_q <= tx_word_d;
            rx_word_q <= rx_word_d;
            rx_valid_q <= rx_valid_d;
            start_q <= start_d;
            seen_q <= seen_d;
        end
    end

    // ------------------------------------------------------------
    // Link-side shift register (sclk domain)
    // ------------------------------------------------------------
    // Chip-select high only re-arms the first-bit flag; the shifter
    // keeps its word so the clk side can collect it after the frame.
    logic first_d;
    logic [FRAME_W-1:0] tx_shift_q;
    logic [FRAME_W-1:0] tx_shift_d;
    logic [FRAME_W-1:0] rx_shift_d;
    logic [CNT_W-1:0] bit_cnt_d;

    always_comb begin
        first_d = 1'b0;
        // mode 0, capture on rising edge
        if (first_q) begin
            tx_shift_d = {tx_word_q[FRAME_W-2:0], 1'b0};
        end else begin
            tx_shift_d = {tx_shift_q[FRAME_W-2:0], 1'b0};
        end
        rx_shift_d = {rx_shift_q[FRAME_W-2:0], sdi};
        if (first_q) begin
            bit_cnt_d = 6'h1;
        end else if (bit_cnt_q == CNT_FULL) begin
            bit_cnt_d = bit_cnt_q;
        end else begin
            bit_cnt_d = bit_cnt_q + 6'h1;
        end
    end

    always_ff @(posedge sclk or posedge convert_chip_select_n) begin
        if (convert_chip_select_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= first_d;
        end
    end

    always_ff @(posedge sclk) begin
        tx_shift_q <= tx_shift_d;
        rx_shift_q <= rx_shift_d;
        bit_cnt_q <= bit_cnt_d;
    end

    // First bit must be out before any link edge, so it is taken
    // from the frozen word until the shifter owns the line.
    assign sdo = first_q ? tx_word_q[FRAME_W-1] : tx_shift_q[FRAME_W-1];

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign multi_function_out_pin = pin_q;
    assign alarm_flags = flags_q;
    assign rx_word = rx_word_q;
    assign rx_valid = rx_valid_q;
    assign conv_start = start_q;

endmodule

// ---- dv/spi_host_model.sv ----
// Host controller model: SPI master, mode 0, one frame per call.
// Assumes the bench spaces frames; sclk idles low outside frames.
module spi_host_model (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        // Deselect just after time zero so the link side sees a
        // clean rising edge of chip-select.
        #1;
        cs_n = 1'b1;
    end

    task automatic xfer(input logic [31:0] tx, input int n,
                        output logic [31:0] rx);
        rx = 32'h0;
        cs_n = 1'b0;
        #40;
        for (int k = 0; k < n; k++) begin
            sdi = tx[31 - (k % 32)];
            #62.5;
            rx = {rx[30:0], sdo};
            sclk = 1'b1;
            #62.5;
            sclk = 1'b0;
        end
        #30;
        cs_n = 1'b1;
        // Released line must not keep showing the last bit
        sdi = ~sdi;
    endtask
endmodule

// ---- dv/adc_alarm_monitor_props.sv ----
// Port-level checks of the alarm monitor on clk.
// Assumes it is bound to every monitor instance.
module adc_alarm_monitor_props
    import alarm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic convert_chip_select_n,
    input wire logic conv_done,
    input wire logic [CODE_W-1:0] conv_code,
    input wire logic [SEL_W-1:0] secondary_pin_function_sel,
    input wire logic input_limit_disable,
    input wire thresh_cfg_t thresh,
    input wire logic alarm_flags_read,
    input wire logic other_pin_level,
    input wire logic multi_function_out_pin,
    input wire alarm_flags_t alarm_flags,
    input wire logic conv_start
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence pin_steady;
        ($stable(secondary_pin_function_sel) && $stable(other_pin_level)
            && $stable(alarm_flags)) [*3];
    endsequence
    sequence cs_close;
        $rose(convert_chip_select_n);
    endsequence

    read_clears_a: assert property (
        alarm_flags_read && !conv_done |=> alarm_flags.tripped == 4'h0)
        else $error("read left tripped flags set");
    flags_hold_a: assert property (
        !conv_done && !alarm_flags_read |=> $stable(alarm_flags))
        else $error("flags moved without a conversion");
    trip_follows_a: assert property (
        conv_done |=> (alarm_flags.tripped & alarm_flags.active)
            == alarm_flags.active)
        else $error("active flag without tripped flag");
    hi_set_a: assert property (
        conv_done && !input_limit_disable && conv_code > thresh.upper
        |=> alarm_flags.active.in_hi)
        else $error("high alarm not raised");
    hi_release_a: assert property (
        conv_done && 16'(conv_code) + 16'(thresh.hyst) + WIDE_ONE
            <= 16'(thresh.upper) |=> !alarm_flags.active.in_hi)
        else $error("high alarm not released");
    lo_set_a: assert property (
        conv_done && !input_limit_disable && conv_code < thresh.lower
        |=> alarm_flags.active.in_lo)
        else $error("low alarm not raised");
    in_mask_a: assert property (
        conv_done && input_limit_disable
        |=> !alarm_flags.active.in_hi && !alarm_flags.active.in_lo)
        else $error("disabled input alarm raised");
    pin_alarm_a: assert property (
        pin_steady ##0 secondary_pin_function_sel == PIN_SEL_ALARM
        |-> multi_function_out_pin == |alarm_flags.active)
        else $error("pin does not show alarm");
    pin_other_a: assert property (
        pin_steady ##0 secondary_pin_function_sel != PIN_SEL_ALARM
        |-> multi_function_out_pin == other_pin_level)
        else $error("pin does not show other level");
    frame_end_a: assert property (
        cs_close |-> ##[1:6] conv_start)
        else $error("no conversion start after frame");
endmodule

bind adc_alarm_monitor adc_alarm_monitor_props i_props (
    .clk, .reset, .convert_chip_select_n, .conv_done, .conv_code,
    .secondary_pin_function_sel, .input_limit_disable, .thresh,
    .alarm_flags_read, .other_pin_level, .multi_function_out_pin,
    .alarm_flags, .conv_start
);

// ---- dv/tb_top.sv ----
// Self-checking bench for the converter alarm monitor.
// Assumes the host model and checker are compiled before it.
module tb_top import alarm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic sclk, cs_n, sdi, sdo, pin, rx_valid, conv_start;
    logic conv_done = 1'b0;
    logic [CODE_W-1:0] conv_code = CODE_RESET;
    logic sup_over = 1'b0, sup_under = 1'b0, sup_dis = 1'b0;
    logic in_dis = 1'b0, rd = 1'b0, other = 1'b0;
    logic [SEL_W-1:0] sel = 2'h0;
    logic [FLAG_W-1:0] mask = 8'h0;
    thresh_cfg_t thresh = '0;
    alarm_flags_t flags;
    logic [FRAME_W-1:0] rx_word, got;
    int n_mismatch = 0, cmp_count = 0;

    initial forever #4 clk = ~clk;

    adc_alarm_monitor i_adc_alarm_monitor (.clk(clk), .reset(reset),
        .sclk(sclk), .convert_chip_select_n(cs_n), .sdi(sdi), .sdo(sdo),
        .conv_done(conv_done), .conv_code(conv_code),
        .supply_over_raw(sup_over), .supply_under_raw(sup_under),
        .secondary_pin_function_sel(sel), .input_limit_disable(in_dis),
        .supply_limit_disable(sup_dis), .thresh(thresh),
        .output_word_control(mask), .alarm_flags_read(rd),
        .other_pin_level(other), .multi_function_out_pin(pin),
        .alarm_flags(flags), .rx_word(rx_word), .rx_valid(rx_valid),
        .conv_start(conv_start));
    spi_host_model i_spi_host_model (.sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .sdo(sdo));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, e, input string m);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic do_reset(input int n);
        @(posedge clk);
        reset <= 1'b1;
        repeat (n) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({pin, flags}, 9'h0, "reset state");
    endtask
    task automatic lim(input logic [CODE_W-1:0] u, l, h);
        @(posedge clk);
        thresh <= '{u, l, h};
    endtask
    task automatic cv(input logic [CODE_W-1:0] c, input logic [7:0] e);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_code <= c;
        @(posedge clk);
        conv_done <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(flags, e, "flags after conversion");
    endtask
    task automatic rd_clr();
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1;
        chk(flags.tripped, 4'h0, "flags after read");
    endtask
    task automatic drive_sup(input logic o, u, d);
        @(posedge clk);
        sup_over <= o;
        sup_under <= u;
        sup_dis <= d;
        // Comparator levels need the synchroniser delay
        repeat (3) @(posedge clk);
    endtask
    task automatic frame(input int n, input logic [31:0] tx, ex,
                         input logic v);
        int i;
        i_spi_host_model.xfer(tx, n, got);
        if (n == 32) chk(got, ex, "word shifted out");
        for (i = 0; i < 12 && conv_start !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (conv_start !== 1'b1) begin
            chk(1'b0, 1'b1, "frame end not seen");
            report_and_stop();
        end else begin
            chk(rx_valid, v, "frame valid");
            if (v) chk(rx_word, tx, "word shifted in");
            repeat (6) @(posedge clk);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_limits();
        lim(14'h2000, 14'h0000, 14'h0004);
        cv(14'h2000, 8'h00);
        cv(14'h2001, 8'h88);
        cv(14'h1ffc, 8'h88);
        cv(14'h1ffb, 8'h08);
        rd_clr();
        lim(14'h3fff, 14'h0100, 14'h0004);
        cv(14'h0100, 8'h00);
        cv(14'h00ff, 8'h44);
        cv(14'h0104, 8'h44);
        cv(14'h0105, 8'h04);
        rd_clr();
        $display("test limits done");
    endtask
    task automatic t_wrap();
        lim(14'h3fff, 14'h3ffa, 14'h3fff);
        cv(14'h3ff9, 8'h44);
        cv(14'h3fff, 8'h44);
        do_reset(2);
        lim(14'h0005, 14'h0000, 14'h3fff);
        cv(14'h0006, 8'h88);
        cv(14'h0000, 8'h88);
        do_reset(2);
        $display("test wrap done");
    endtask
    task automatic t_disable();
        lim(14'h2000, 14'h0000, 14'h0000);
        in_dis <= 1'b1;
        cv(14'h3000, 8'h00);
        @(posedge clk);
        in_dis <= 1'b0;
        cv(14'h3000, 8'h88);
        cv(14'h0000, 8'h08);
        rd_clr();
        drive_sup(1'b1, 1'b0, 1'b0);
        cv(14'h0000, 8'h22);
        drive_sup(1'b1, 1'b0, 1'b1);
        cv(14'h0000, 8'h02);
        drive_sup(1'b0, 1'b1, 1'b0);
        cv(14'h0000, 8'h13);
        $display("test disable done");
    endtask
    task automatic t_pin();
        for (int s = 0; s < 4; s++) begin
            for (int o = 0; o < 2; o++) begin
                @(posedge clk);
                sel <= 2'(s);
                other <= 1'(o);
                repeat (4) @(posedge clk);
                #1;
                chk(pin, s == 1 ? 1'b1 : 1'(o), "pin level");
            end
        end
        @(posedge clk);
        sel <= PIN_SEL_ALARM;
        drive_sup(1'b0, 1'b0, 1'b0);
        cv(14'h0000, 8'h03);
        chk(pin, 1'b0, "pin after clear");
        $display("test pin done");
    endtask
    task automatic t_frame();
        rd_clr();
        lim(14'h2000, 14'h0000, 14'h0000);
        mask <= 8'h0f;
        cv(14'h3000, 8'h88);
        frame(32, 32'ha5c30f1e, {14'h3000, 8'h08, 10'h0}, 1'b1);
        frame(16, 32'h0000ffff, 32'h0, 1'b0);
        $display("test frame done");
    endtask

    initial begin
        do_reset(5);
        t_limits();
        t_wrap();
        t_disable();
        t_pin();
        t_frame();
        report_and_stop();
    end
endmodule
